/* include/tws_consts.svh */
// Constants of the two-wire serial register block: indices, resets, bits, codes.
// Assumes an APB bus with 32-bit words; byte address is four times the index.
`ifndef TWS_CONSTS_SVH
`define TWS_CONSTS_SVH

// Register indices (byte address = 4 * index)
`define TWS_IDX_RATE 8'hB8
`define TWS_IDX_STAT 8'hB9
`define TWS_IDX_ADDR 8'hBA
`define TWS_IDX_DATA 8'hBB
`define TWS_IDX_CTRL 8'hBC
`define TWS_IDX_MASK 8'hBD

// Reset values
`define TWS_RST_DATA 8'h01
`define TWS_RST_ADDR 8'h02
`define TWS_RST_MASK 7'h00
`define TWS_RST_RATE 8'h00

// Control register bit positions
`define TWS_B_DONE 7
`define TWS_B_ACK 6
`define TWS_B_STA 5
`define TWS_B_STO 4
`define TWS_B_EN 2
`define TWS_B_IE 0

// Status codes
`define TWS_ST_BUSERR 8'h00
`define TWS_ST_START 8'h08
`define TWS_ST_RSTART 8'h10
`define TWS_ST_SLAW_ACK 8'h18
`define TWS_ST_SLAW_NAK 8'h20
`define TWS_ST_MTD_ACK 8'h28
`define TWS_ST_MTD_NAK 8'h30
`define TWS_ST_ARB 8'h38
`define TWS_ST_SLAR_ACK 8'h40
`define TWS_ST_SLAR_NAK 8'h48
`define TWS_ST_MRD_ACK 8'h50
`define TWS_ST_MRD_NAK 8'h58
`define TWS_ST_OWN_W 8'h60
`define TWS_ST_GC 8'h70
`define TWS_ST_SRD_ACK 8'h80
`define TWS_ST_SRD_NAK 8'h88
`define TWS_ST_GCD_ACK 8'h90
`define TWS_ST_GCD_NAK 8'h98
`define TWS_ST_SSTOP 8'hA0
`define TWS_ST_OWN_R 8'hA8
`define TWS_ST_STD_ACK 8'hB8
`define TWS_ST_STD_NAK 8'hC0
`define TWS_ST_IDLE 8'hF8

`endif

/* include/tws_pkg.sv */
// Types of the two-wire serial register block.
// Assumes tws_consts.svh holds the numeric constants.
package tws_pkg;
  typedef enum logic [2:0] {
    M_IDLE, M_START, M_BYTE, M_RS1, M_RS2, M_STOP1, M_STOP2
  } tws_state_t;
endpackage

/* logic/tws_top.sv */
// Two-wire serial interface: APB registers, byte engine, master conditions.
// Assumes open-drain pins resolved outside and an APB master on MCLK_I.
// How it works
// - Data register holds byte to send, or byte last received.
// - Data register takes writes only while the job-done flag is set.
// - Data stays put while flag set; shifting out also shifts bus in.
// - Data register mirrors the last bus byte; reset loads 01.
// - Losing arbitration drops to slave without losing received bits.
// - Acknowledge is driven by hardware as set by the software ack-enable bit.
// - Job-done set at end of operation; SCL held low while set if master or addressed.
// - Job-done cleared only by writing one; clearing starts next step.
// - With ack enabled, ack own address, general call, received data.
// - Ack disabled means not addressable until enabled again.
// - START request waits for a free bus, then sends START.
// - Master STOP request sends STOP and clears itself afterwards.
// - Slave STOP request only unaddresses and releases both lines.
// - Write collision set by early data write, cleared by legal one.
// - Enable hands pins to the unit; disable aborts at once.
// - Interrupt asserted while enable, global enable and flag are set.
// - General call recognised only with address bit 0 set.
// - Own 7-bit address sits in address register bits 7:1.
// - Mask bits at one skip comparing the matching address bit.
// - Prescale code 0..3 selects bit-rate factor 1, 4, 16, 64.
// - Illegal START/STOP: status 00, release, clear STOP request.
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps
`include "tws_consts.svh"

module tws_top
  import tws_pkg::*;
(
  input  wire logic        MCLK_I,
  input  wire logic        RESET_N_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [11:0] PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  input  wire logic        GIE_I,
  input  wire logic        SCL_I,
  output logic             SCL_O,
  output logic             SCL_OE_O,
  input  wire logic        SDA_I,
  output logic             SDA_O,
  output logic             SDA_OE_O,
  output logic             IRQ_O
);

  // Software registers
  logic [7:0]  rate;
  logic [1:0]  ps;
  logic [7:0]  own;
  logic [7:1]  mask;
  logic        ack_en;
  logic        sta;
  logic        ie;
  logic        en;
  logic        job_done;
  logic        stop_req;
  logic        wc;
  logic        kick;
  logic [31:0] rd_q;
  logic        err_q;

  // Engine state
  tws_state_t  state;
  logic [7:0]  dreg;
  logic [3:0]  bitcnt;
  logic [14:0] tmr;
  logic [7:0]  code;
  logic        master;
  logic        addressed;
  logic        xmit;
  logic        rw;
  logic        gc;
  logic        lost;
  logic        addr_phase;
  logic        ack_rx;
  logic        sda_bit;
  logic        scl_lo;
  logic        busy;
  logic        done_evt;
  logic        stop_clr;

  // Pin synchronisers and edge history
  logic        scl_m;
  logic        scl_s;
  logic        scl_q;
  logic        sda_m;
  logic        sda_s;
  logic        sda_q;

  // Pins cross two flops; a third flop keeps the previous sample for edge detection
  always_ff @(posedge MCLK_I) begin
    if (!RESET_N_I) begin
      scl_m <= 1'h1;
      scl_s <= 1'h1;
      scl_q <= 1'h1;
      sda_m <= 1'h1;
      sda_s <= 1'h1;
      sda_q <= 1'h1;
    end else begin
      scl_m <= SCL_I;
      scl_s <= scl_m;
      scl_q <= scl_s;
      sda_m <= SDA_I;
      sda_s <= sda_m;
      sda_q <= sda_s;
    end
  end

  // Bus events
  wire logic rise      = !scl_q && scl_s;
  wire logic fall      = scl_q && !scl_s;
  wire logic start_det = scl_s && scl_q && sda_q && !sda_s;
  wire logic stop_det  = scl_s && scl_q && !sda_q && sda_s;
  wire logic gen       = !(state == M_IDLE || state == M_BYTE);
  wire logic snd       = master ? (addr_phase || xmit) : (addressed && xmit && !addr_phase);
  wire logic ack       = ack_rx;

  // Address compare with mask; general call only when enabled
  wire logic match  = ((dreg[7:1] ^ own[7:1]) & ~mask) == 7'h00;
  wire logic gc_hit = (dreg == 8'h00) && own[0];

  // Half SCL period: (rate + 1) scaled by 1, 4, 16 or 64
  wire logic [14:0] half = ({7'h00, rate} + 15'h0001) << {ps, 1'h0};
  wire logic        tdone = tmr >= half;

  // Any START or STOP inside a byte we take part in is illegal
  wire logic err = (start_det || stop_det) && (bitcnt != 4'h0)
                   && (addressed || (master && state == M_BYTE));

  // Status at the end of a byte
  wire logic [7:0] end_code =
    master ? (addr_phase ? (rw ? (ack ? `TWS_ST_SLAR_ACK : `TWS_ST_SLAR_NAK)
                               : (ack ? `TWS_ST_SLAW_ACK : `TWS_ST_SLAW_NAK))
                         : (xmit ? (ack ? `TWS_ST_MTD_ACK : `TWS_ST_MTD_NAK)
                                 : (ack ? `TWS_ST_MRD_ACK : `TWS_ST_MRD_NAK)))
    : addr_phase ? (gc ? `TWS_ST_GC : (xmit ? `TWS_ST_OWN_R : `TWS_ST_OWN_W))
    : xmit ? (ack ? `TWS_ST_STD_ACK : `TWS_ST_STD_NAK)
    : gc ? (ack ? `TWS_ST_GCD_ACK : `TWS_ST_GCD_NAK)
    : (ack ? `TWS_ST_SRD_ACK : `TWS_ST_SRD_NAK);

  // APB decode: word aligned, index in address bits 9:2
  wire logic [7:0] idx     = PADDR_I[9:2];
  wire logic       aligned = (PADDR_I[11:10] == 2'h0) && (PADDR_I[1:0] == 2'h0);
  wire logic       s_rate  = aligned && (idx == `TWS_IDX_RATE);
  wire logic       s_stat  = aligned && (idx == `TWS_IDX_STAT);
  wire logic       s_addr  = aligned && (idx == `TWS_IDX_ADDR);
  wire logic       s_data  = aligned && (idx == `TWS_IDX_DATA);
  wire logic       s_ctrl  = aligned && (idx == `TWS_IDX_CTRL);
  wire logic       s_mask  = aligned && (idx == `TWS_IDX_MASK);
  wire logic       mapped  = s_rate || s_stat || s_addr || s_data || s_ctrl || s_mask;
  wire logic       wr      = PSEL_I && PENABLE_I && PWRITE_I;
  wire logic [7:0] wd      = PWDATA_I[7:0];
  wire logic       ctl_wr  = wr && s_ctrl;
  wire logic       data_wr = wr && s_data;

  // Status reads idle code while no job is pending
  wire logic [7:0] stat_code = job_done ? code : `TWS_ST_IDLE;
  wire logic [7:0] stat_rd   = {stat_code[7:3], 1'h0, ps};
  wire logic [7:0] ctrl_rd = {job_done, ack_en, sta, stop_req, wc, en, 1'h0, ie};
  wire logic [7:0] rd_byte = s_rate ? rate : s_stat ? stat_rd : s_addr ? own
                           : s_data ? dreg : s_ctrl ? ctrl_rd
                           : s_mask ? {mask, 1'h0} : 8'h00;

  // Zero wait states; read data and error are latched in the setup cycle
  assign PREADY_O  = PSEL_I && PENABLE_I;
  assign PRDATA_O  = rd_q;
  assign PSLVERR_O = PREADY_O && err_q;

  // Open-drain pins: output low, enable while pulling down
  assign SCL_O    = 1'h0;
  assign SDA_O    = 1'h0;
  assign SCL_OE_O = en && (scl_lo || (job_done && addressed));
  assign SDA_OE_O = en && !sda_bit;
  assign IRQ_O    = ie && GIE_I && job_done;

  // APB read path
  always_ff @(posedge MCLK_I) begin
    if (!RESET_N_I) begin
      rd_q  <= 32'h0000_0000;
      err_q <= 1'h0;
    end else if (PSEL_I && !PENABLE_I) begin
      rd_q  <= {24'h00_0000, rd_byte};
      err_q <= !mapped;
    end
  end

  // Plain software registers; the START request is never cleared by hardware
  always_ff @(posedge MCLK_I) begin
    if (!RESET_N_I) begin
      rate   <= `TWS_RST_RATE;
      ps     <= 2'h0;
      own    <= `TWS_RST_ADDR;
      mask   <= `TWS_RST_MASK;
      ack_en <= 1'h0;
      sta    <= 1'h0;
      ie     <= 1'h0;
      en     <= 1'h0;
    end else begin
      if (wr && s_rate) rate <= wd;
      if (wr && s_stat) ps <= wd[1:0];
      if (wr && s_addr) own <= wd;
      if (wr && s_mask) mask <= wd[7:1];
      if (ctl_wr) begin
        ack_en <= wd[`TWS_B_ACK];
        sta    <= wd[`TWS_B_STA];
        ie     <= wd[`TWS_B_IE];
        en     <= wd[`TWS_B_EN];
      end
    end
  end

  // Flags shared with the engine; a hardware set beats a software clear
  always_ff @(posedge MCLK_I) begin
    if (!RESET_N_I) begin
      job_done <= 1'h0;
      stop_req <= 1'h0;
      wc       <= 1'h0;
      kick     <= 1'h0;
    end else begin
      job_done <= done_evt || (job_done && !(ctl_wr && wd[`TWS_B_DONE]));
      kick     <= ctl_wr && wd[`TWS_B_DONE] && job_done && !done_evt;
      if (data_wr) wc <= !job_done;
      if (ctl_wr) stop_req <= wd[`TWS_B_STO];
      else if (stop_clr) stop_req <= 1'h0;
    end
  end

  // Byte engine, master clock generator and condition sequencer
  always_ff @(posedge MCLK_I) begin
    if (!RESET_N_I) begin
      state      <= M_IDLE;
      dreg       <= `TWS_RST_DATA;
      bitcnt     <= 4'h0;
      tmr        <= 15'h0000;
      code       <= `TWS_ST_IDLE;
      master     <= 1'h0;
      addressed  <= 1'h0;
      xmit       <= 1'h0;
      rw         <= 1'h0;
      gc         <= 1'h0;
      lost       <= 1'h0;
      addr_phase <= 1'h0;
      ack_rx     <= 1'h0;
      sda_bit    <= 1'h1;
      scl_lo     <= 1'h0;
      busy       <= 1'h0;
      done_evt   <= 1'h0;
      stop_clr   <= 1'h0;
    end else begin
      done_evt <= 1'h0;
      stop_clr <= 1'h0;
      tmr      <= tdone ? tmr : tmr + 15'h0001;
      if (data_wr && job_done) dreg <= wd;
      if (!en) begin
        // Switched off: drop the transfer state and let go of both lines
        state      <= M_IDLE;
        master     <= 1'h0;
        addressed  <= 1'h0;
        lost       <= 1'h0;
        addr_phase <= 1'h0;
        bitcnt     <= 4'h0;
        sda_bit    <= 1'h1;
        scl_lo     <= 1'h0;
        busy       <= 1'h0;
      end else begin
        // Condition sequencer; timer restarts on every step except a return to M_IDLE
        unique case (state)
          M_IDLE: begin
            if (sta && !job_done && !busy) begin
              state   <= M_START;
              sda_bit <= 1'h0;
              tmr     <= 15'h0000;
            end
          end
          M_START: begin
            if (tdone) begin
              code       <= master ? `TWS_ST_RSTART : `TWS_ST_START;
              done_evt   <= 1'h1;
              master     <= 1'h1;
              scl_lo     <= 1'h1;
              addr_phase <= 1'h1;
              xmit       <= 1'h1;
              bitcnt     <= 4'h0;
              tmr        <= 15'h0000;
              state      <= M_BYTE;
            end
          end
          M_BYTE: begin
            if (kick && stop_req) begin
              state   <= M_STOP1;
              sda_bit <= 1'h0;
              tmr     <= 15'h0000;
            end else if (kick && sta) begin
              state   <= M_RS1;
              sda_bit <= 1'h1;
              tmr     <= 15'h0000;
            end else if (kick) begin
              sda_bit <= snd ? dreg[7] : 1'h1;
              tmr     <= 15'h0000;
            end else if (scl_lo) begin
              // Low phase is stretched while software owns the job; the timer
              // waits for the synchronised low so the fall is acted on first
              if (scl_s) begin
                tmr <= 15'h0000;
              end else if (tdone && !job_done && !done_evt) begin
                scl_lo <= 1'h0;
                tmr    <= 15'h0000;
              end
            end else if (!scl_s) begin
              tmr <= 15'h0000;
            end else if (tdone) begin
              scl_lo <= 1'h1;
              tmr    <= 15'h0000;
            end
          end
          M_RS1: begin
            if (tdone) begin
              scl_lo <= 1'h0;
              tmr    <= 15'h0000;
              state  <= M_RS2;
            end
          end
          M_RS2: begin
            if (!scl_s) begin
              tmr <= 15'h0000;
            end else if (tdone) begin
              sda_bit <= 1'h0;
              tmr     <= 15'h0000;
              state   <= M_START;
            end
          end
          M_STOP1: begin
            if (tdone) begin
              scl_lo <= 1'h0;
              tmr    <= 15'h0000;
              state  <= M_STOP2;
            end
          end
          M_STOP2: begin
            if (!scl_s) begin
              tmr <= 15'h0000;
            end else if (tdone) begin
              sda_bit  <= 1'h1;
              master   <= 1'h0;
              stop_clr <= 1'h1;
              state    <= M_IDLE;
            end
          end
        endcase

        // Slave side: kick releases or loads the first bit, or unaddresses
        if (kick && !master) begin
          if (stop_req) begin
            addressed <= 1'h0;
            sda_bit   <= 1'h1;
            stop_clr  <= 1'h1;
          end else begin
            sda_bit <= snd ? dreg[7] : 1'h1;
          end
        end

        if (start_det) busy <= 1'h1;
        if (stop_det) busy <= 1'h0;

        if (err) begin
          code       <= `TWS_ST_BUSERR;
          done_evt   <= 1'h1;
          stop_clr   <= 1'h1;
          master     <= 1'h0;
          addressed  <= 1'h0;
          bitcnt     <= 4'h0;
          sda_bit    <= 1'h1;
          scl_lo     <= 1'h0;
          state      <= M_IDLE;
        end else if (start_det) begin
          bitcnt     <= 4'h0;
          addr_phase <= 1'h1;
          lost       <= 1'h0;
          if (!master) addressed <= 1'h0;
        end else if (stop_det && addressed) begin
          code      <= `TWS_ST_SSTOP;
          done_evt  <= 1'h1;
          addressed <= 1'h0;
          bitcnt    <= 4'h0;
          sda_bit   <= 1'h1;
        end else if (stop_det) begin
          bitcnt     <= 4'h0;
          addr_phase <= 1'h0;
        end else if (!gen && rise && bitcnt < 4'h9) begin
          // Shift in whatever is on the bus, even our own bits
          if (bitcnt < 4'h8 && !job_done) dreg <= {dreg[6:0], sda_s};
          if (bitcnt == 4'h8) ack_rx <= !sda_s;
          // Arbitration loss: stop clocking, keep shifting as a slave
          if (master && snd && sda_bit && !sda_s && bitcnt < 4'h8) begin
            master <= 1'h0;
            lost   <= 1'h1;
            scl_lo <= 1'h0;
            state  <= M_IDLE;
          end
          bitcnt <= bitcnt + 4'h1;
        end else if (!gen && fall && bitcnt == 4'h8) begin
          // Acknowledge slot
          if (addr_phase && !master) begin
            if ((match || gc_hit) && ack_en) begin
              addressed <= 1'h1;
              xmit      <= dreg[0];
              gc        <= gc_hit;
              sda_bit   <= 1'h0;
            end else begin
              addressed <= 1'h0;
              sda_bit   <= 1'h1;
            end
          end else if (addr_phase) begin
            rw      <= dreg[0];
            sda_bit <= 1'h1;
          end else if (!xmit && (master || addressed)) begin
            sda_bit <= !ack_en;
          end else begin
            sda_bit <= 1'h1;
          end
        end else if (!gen && fall && bitcnt == 4'h9) begin
          // End of byte: hand the job to software
          bitcnt     <= 4'h0;
          addr_phase <= 1'h0;
          sda_bit    <= 1'h1;
          if (master) begin
            code     <= end_code;
            done_evt <= 1'h1;
            if (addr_phase) xmit <= !rw;
          end else if (addressed) begin
            code     <= end_code;
            done_evt <= 1'h1;
            if (!ack_rx && !addr_phase) addressed <= 1'h0;
          end else if (lost) begin
            code     <= `TWS_ST_ARB;
            done_evt <= 1'h1;
            lost     <= 1'h0;
          end
        end else if (!gen && fall && bitcnt != 4'h0) begin
          sda_bit <= snd ? dreg[7] : 1'h1;
        end
      end
    end
  end

  // Checks
  chk_irq_level: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
    IRQ_O == (ie && GIE_I && job_done)) else $error("irq level wrong");
  chk_scl_stretch: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
    (en && job_done && master && state == M_BYTE) |-> SCL_OE_O) else $error("scl not held");
  chk_data_stable: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
    (job_done && $past(job_done) && !$past(data_wr)) |-> $stable(dreg)) else $error("data moved");
  chk_data_write: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
    (data_wr && job_done) |=> dreg == $past(wd)) else $error("data write lost");
  chk_wc_set: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
    (data_wr && !job_done) |=> wc ##1 (wc || $past(data_wr))) else $error("wc not set");
  chk_wc_clear: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
    (data_wr && job_done) |=> !wc) else $error("wc not cleared");
  chk_stop_clear: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
    (stop_clr && !ctl_wr) |=> !stop_req) else $error("stop not cleared");
  chk_en_off: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
    !en |=> (state == M_IDLE && !master && !addressed)) else $error("not aborted");
  chk_job_clear: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
    (ctl_wr && wd[`TWS_B_DONE] && job_done && !done_evt) |=> (!job_done && kick))
    else $error("job clear failed");
  chk_bus_error: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
    (en && err) |=> (code == `TWS_ST_BUSERR && !master && !addressed) ##1 job_done)
    else $error("bus error not reported");

endmodule

/* testbench/two_wire_serial_register_control_tb.sv */
// Self-checking bench: APB register traffic and one master write on the bus.
// Assumes tws_top answers with no wait states and a pulled-up open-drain bus.
`timescale 1ns/1ps
module two_wire_serial_register_control_tb;
  logic        mclk, rst_n, psel, pen, pwr, gie;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic        pready, pslverr, scl_oe, sda_oe, irq, pull, stopped;
  logic [7:0]  got_byte;
  logic [32:0] exq[$];
  int          fail_count, num_checks, seed;
  wire         scl_line = ~scl_oe;
  wire         sda_line = ~sda_oe & ~pull;

  tws_top i_dut (.MCLK_I(mclk), .RESET_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .GIE_I(gie), .SCL_I(scl_line), .SCL_O(),
    .SCL_OE_O(scl_oe), .SDA_I(sda_line), .SDA_O(), .SDA_OE_O(sda_oe), .IRQ_O(irq));
  tws_slave_model i_peer (.scl_i(scl_line), .sda_i(sda_line), .pull_o(pull),
    .byte_o(got_byte), .stop_o(stopped));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; reads leave their expectation for the monitor
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    @(posedge mclk);
    psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwdata <= d;
    if (!w) exq.push_back(e);
    @(posedge mclk);
    pen <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    psel <= 1'b0; pen <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    apb(1'b0, a, 32'h0, e);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask

  // Skip the launching edge so a flag cleared there is not seen as still set
  task automatic wait_irq;
    int i;
    @(posedge mclk);
    for (i = 0; i < 3000 && irq !== 1'b1; i++) @(posedge mclk);
    chk({32'h0, irq}, 33'h1);
  endtask

  // Oldest expectation is matched against each completed read
  always @(posedge mclk)
    if (psel && pen && pready === 1'b1 && !pwr) chk({pslverr, prdata}, exq.pop_front());

  task final_report;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge mclk);
    fail_count++;
    final_report;
  end

  initial begin
    int i;
    seed = 32'h5EDD; rst_n = 1'b0; psel = 1'b0; pen = 1'b0; pwr = 1'b0;
    paddr = 12'h0; pwdata = 32'h0; gie = 1'b1; fail_count = 0; num_checks = 0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    rd(12'h2EC, 33'h001); rd(12'h2F0, 33'h000); rd(12'h2F4, 33'h000);
    rd(12'h2E8, 33'h002); rd(12'h2E4, 33'h0F8); rd(12'h2E0, 33'h000);
    rd(12'h100, 33'h1_0000_0000);
    $display("test reset values done");
    wr(12'h2F0, 32'h02); rd(12'h2F0, 33'h000);
    wr(12'h2EC, 32'hA5); rd(12'h2EC, 33'h001);
    rd(12'h2F0, 33'h008);
    r = $random(seed);
    wr(12'h2F4, r); rd(12'h2F4, {25'h0, r[7:1], 1'b0});
    wr(12'h2E0, r); rd(12'h2E0, {25'h0, r[7:0]});
    for (i = 0; i < 4; i++) begin
      wr(12'h2E4, i); rd(12'h2E4, 33'h0F8 | i);
    end
    // A few cycles per half period keeps SDA changes well inside the low phase
    wr(12'h2E4, 32'h0); wr(12'h2E0, 32'h4);
    $display("test register access done");
    wr(12'h2F0, 32'hA5); wait_irq;
    rd(12'h2E4, 33'h008); rd(12'h2F0, 33'h0AD);
    repeat (40) @(posedge mclk);
    chk({32'h0, scl_oe}, 33'h1);
    wr(12'h2EC, 32'hA4); rd(12'h2EC, 33'h0A4); rd(12'h2F0, 33'h0A5);
    wr(12'h2F0, 32'h85); wait_irq;
    rd(12'h2E4, 33'h018); chk({25'h0, got_byte}, 33'h0A4);
    gie <= 1'b0;
    repeat (2) @(posedge mclk);
    chk({32'h0, irq}, 33'h0);
    gie <= 1'b1;
    wr(12'h2F0, 32'h95);
    for (i = 0; i < 500 && stopped !== 1'b1; i++) @(posedge mclk);
    repeat (8) @(posedge mclk);
    chk({32'h0, stopped}, 33'h1); rd(12'h2F0, 33'h005);
    chk({32'h0, irq}, 33'h0);
    $display("test master write done");
    wr(12'h2F0, 32'hA5); wait_irq;
    wr(12'h2F0, 32'h00);
    repeat (2) @(posedge mclk);
    chk({31'h0, scl_oe, sda_oe}, 33'h0);
    $display("test disable done");
    final_report;
  end
endmodule

/* testbench/tws_slave_model.sv */
// Behavioural slave on the two-wire bus: acks its own address byte and keeps it.
// Assumes the bench resolves both open-drain lines with pull-ups.
`timescale 1ns/1ps
module tws_slave_model #(
  parameter logic [6:0] ADDR = 7'h52
) (
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            pull_o,
  output logic [7:0]      byte_o,
  output logic            stop_o
);
  int         cnt;
  logic [7:0] shift;

  // Idle until the first start, so power-up glitches are ignored
  initial begin
    pull_o = 1'b0;
    byte_o = 8'h00;
    stop_o = 1'b0;
    shift  = 8'h00;
    cnt    = 10;
  end

  // Start restarts the bit count; stop is flagged to the bench
  always @(negedge sda_i) if (scl_i) begin
    cnt    = 0;
    stop_o = 1'b0;
  end
  always @(posedge sda_i) if (scl_i) stop_o = 1'b1;

  // Bits taken on the rising clock, MSB first
  always @(posedge scl_i) if (cnt < 8) begin
    shift = {shift[6:0], sda_i};
    cnt   = cnt + 1;
  end

  // Ack only our address, released after the ack bit so the line floats high
  always @(negedge scl_i) begin
    if (cnt == 8) begin
      byte_o = shift;
      pull_o = (shift[7:1] == ADDR);
      cnt    = 9;
    end else if (cnt == 9) begin
      pull_o = 1'b0;
      cnt    = 10;
    end
  end
endmodule
